//--- rtl/flash_status_cfg.svh
`ifndef FLASH_STATUS_CFG_SVH
`define FLASH_STATUS_CFG_SVH

// Command codes taken at the end of a frame.
`define FSW_CMD_WRITE_ENABLE 8'h06
`define FSW_CMD_WRITE_DISABLE 8'h04
`define FSW_CMD_STATUS_WRITE 8'h01
`define FSW_CMD_PAGE_WRITE 8'h02
`define FSW_CMD_SECTOR_WIPE 8'h20
`define FSW_CMD_BLOCK32_WIPE 8'h52
`define FSW_CMD_BLOCK64_WIPE 8'hD8
`define FSW_CMD_CHIP_WIPE_A 8'h60
`define FSW_CMD_CHIP_WIPE_B 8'hC7
`define FSW_CMD_SUSPEND 8'h75
`define FSW_CMD_RESUME 8'h7A

// Frame lengths in whole bytes.
`define FSW_LEN_STATUS_MIN 3'h2
`define FSW_LEN_STATUS_FULL 3'h3
`define FSW_LEN_ADDR 3'h4
`define FSW_LEN_PAGE_MIN 3'h5
`define FSW_LEN_CMD 3'h1
`define FSW_LEN_MAX 3'h7

// Status word bit positions.
`define FSW_BIT_BUSY 0
`define FSW_BIT_WRITE_LATCH 1
`define FSW_BIT_PROTECT_LO 2
`define FSW_BIT_PROTECT_HI 6
`define FSW_BIT_STATUS_PROT_LO 7
`define FSW_BIT_STATUS_PROT_HI 8
`define FSW_BIT_QUAD_LANE 9
`define FSW_BIT_PROGRAM_PAUSED 10
`define FSW_BIT_LOCK_LO 11
`define FSW_BIT_LOCK_HI 13
`define FSW_BIT_RANGE_INVERT 14
`define FSW_BIT_ERASE_PAUSED 15

// Defaults of the stored fields.
`define FSW_RST_PROTECT 5'h00
`define FSW_RST_STATUS_PROT 2'h0
`define FSW_RST_LOCK 3'h0
`define FSW_RST_WORD 16'h0000

// Protected range sizes, less one, for the 64KB array.
`define FSW_SIZE_4K_M1 16'h0FFF
`define FSW_SIZE_8K_M1 16'h1FFF
`define FSW_SIZE_16K_M1 16'h3FFF
`define FSW_SIZE_32K_M1 16'h7FFF
`define FSW_ARRAY_TOP 16'hFFFF

// Busy durations.
`define FSW_CLK_PERIOD_NS 100
`define FSW_T_STATUS_NS 5000
`define FSW_T_PROGRAM_NS 20000
`define FSW_T_SECTOR_NS 100000
`define FSW_T_BLOCK_NS 400000
`define FSW_T_CHIP_NS 2000000
`define FSW_STATUS_CYCLES (`FSW_T_STATUS_NS / `FSW_CLK_PERIOD_NS)
`define FSW_PROGRAM_CYCLES (`FSW_T_PROGRAM_NS / `FSW_CLK_PERIOD_NS)
`define FSW_SECTOR_CYCLES (`FSW_T_SECTOR_NS / `FSW_CLK_PERIOD_NS)
`define FSW_BLOCK_CYCLES (`FSW_T_BLOCK_NS / `FSW_CLK_PERIOD_NS)
`define FSW_CHIP_CYCLES (`FSW_T_CHIP_NS / `FSW_CLK_PERIOD_NS)

`endif

//--- rtl/flash_status_pkg.sv
package flash_status_pkg;
  typedef enum logic [1:0] {
    OP_IDLE,
    OP_STATUS,
    OP_PROGRAM,
    OP_ERASE
  } op_t;
  typedef logic [15:0] timer_t;
endpackage

//--- rtl/flash_status_write_protect.sv
// Contract
// - Busy flag high exactly while operation runs.
// - Write latch low rejects writes, programs, erases.
// - Block protect bits change only by status write.
// - Refuse program or erase inside protected range.
// - Block protect frozen under hardware status protection.
// - Chip erase runs with bits2..0 set, invert set.
// - Protect bits 00: status write needs latch only.
// - Protect 01 and pin low locks status.
// - Protect 01 and pin high allows latched write.
// - Protect 10 locks until power cycle, cleared then.
// - Protect 11 refuses status writes forever.
// - Quad lane enable stored, default zero, repurposes pins.
// - Three lock bits set once, never clear.
// - Range invert bit stored, combined with protect bits.
// - Suspend sets erase or program paused flag.
// - Resume and power cycle clear paused flags.
// - Invert set protects the complement of the range in the 64KB array.
// - Partial final byte rejects the whole frame.
`timescale 1ns/1ps
`include "flash_status_cfg.svh"

module flash_status_write_protect #(
  parameter int unsigned CHIP_WIPE_CYCLES = `FSW_CHIP_CYCLES
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_power_cycle,
  input wire logic i_sclk,
  input wire logic i_cs_n,
  input wire logic i_si,
  input wire logic i_wp_n,
  output flash_status_pkg::timer_t o_status_word,
  output logic o_quad_lane_enable,
  output logic [2:0] o_security_lock
);
  import flash_status_pkg::*;

  // Link side: shifts the frame in and keeps a snapshot of it that stays put once the serial clock stops.
  logic link_rst_reg;
  logic link_rst_next;
  logic frame_clr;
  logic [7:0] shift_reg, shift_next;
  logic [2:0] bitpos_reg, bitpos_next;
  logic [2:0] nbyte_reg, nbyte_next;
  logic [7:0] cmd_byte_reg, cmd_byte_next;
  logic [7:0] arg1_reg, arg1_next;
  logic [7:0] arg2_reg, arg2_next;
  logic [7:0] arg3_reg, arg3_next;
  logic [2:0] frame_bytes_reg, frame_bytes_next;
  logic frame_partial_reg, frame_partial_next;
  logic frame_tog_reg, frame_tog_next;
  logic [7:0] shifted;

  assign frame_clr = link_rst_reg | i_cs_n;

  always_comb begin
    shifted = {shift_reg[6:0], i_si};
    shift_next = shifted;
    bitpos_next = bitpos_reg + 3'h1;
    nbyte_next = nbyte_reg;
    if (bitpos_reg == 3'h7 && nbyte_reg != `FSW_LEN_MAX) begin
      nbyte_next = nbyte_reg + 3'h1;
    end
    frame_tog_next = frame_tog_reg;
    if (bitpos_reg == 3'h0 && nbyte_reg == 3'h0) begin
      frame_tog_next = ~frame_tog_reg;
    end
    cmd_byte_next = cmd_byte_reg;
    arg1_next = arg1_reg;
    arg2_next = arg2_reg;
    arg3_next = arg3_reg;
    if (bitpos_reg == 3'h7) begin
      case (nbyte_reg)
        3'h0: cmd_byte_next = shifted;
        3'h1: arg1_next = shifted;
        3'h2: arg2_next = shifted;
        3'h3: arg3_next = shifted;
        default: cmd_byte_next = cmd_byte_reg;
      endcase
    end
    frame_bytes_next = nbyte_next;
    frame_partial_next = (bitpos_next != 3'h0);
  end

  always_ff @(posedge i_sclk or posedge frame_clr) begin
    if (frame_clr) begin
      bitpos_reg <= 3'h0;
      nbyte_reg <= 3'h0;
    end else begin
      bitpos_reg <= bitpos_next;
      nbyte_reg <= nbyte_next;
    end
  end

  always_ff @(posedge i_sclk or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      shift_reg <= 8'h00;
      cmd_byte_reg <= 8'h00;
      arg1_reg <= 8'h00;
      arg2_reg <= 8'h00;
      arg3_reg <= 8'h00;
      frame_bytes_reg <= 3'h0;
      frame_partial_reg <= 1'b0;
      frame_tog_reg <= 1'b0;
    end else begin
      shift_reg <= shift_next;
      cmd_byte_reg <= cmd_byte_next;
      arg1_reg <= arg1_next;
      arg2_reg <= arg2_next;
      arg3_reg <= arg3_next;
      frame_bytes_reg <= frame_bytes_next;
      frame_partial_reg <= frame_partial_next;
      frame_tog_reg <= frame_tog_next;
    end
  end

  // Core side: pin and toggle synchronisers.
  logic cs_meta_reg, cs_sync_reg, cs_last_reg;
  logic tog_meta_reg, tog_sync_reg, tog_seen_reg;
  logic wp_meta_reg, wp_sync_reg;
  logic cs_meta_next, cs_sync_next, cs_last_next;
  logic tog_meta_next, tog_sync_next, tog_seen_next;
  logic wp_meta_next, wp_sync_next;
  logic frame_done;

  always_comb begin
    link_rst_next = i_rst;
    cs_meta_next = i_rst ? 1'b1 : i_cs_n;
    cs_sync_next = i_rst ? 1'b1 : cs_meta_reg;
    cs_last_next = i_rst ? 1'b1 : cs_sync_reg;
    tog_meta_next = i_rst ? 1'b0 : frame_tog_reg;
    tog_sync_next = i_rst ? 1'b0 : tog_meta_reg;
    tog_seen_next = i_rst ? 1'b0 : (frame_done ? tog_sync_reg : tog_seen_reg);
    wp_meta_next = i_rst ? 1'b0 : i_wp_n;
    wp_sync_next = i_rst ? 1'b0 : wp_meta_reg;
  end

  always_ff @(posedge i_clk) begin
    link_rst_reg <= link_rst_next;
    cs_meta_reg <= cs_meta_next;
    cs_sync_reg <= cs_sync_next;
    cs_last_reg <= cs_last_next;
    tog_meta_reg <= tog_meta_next;
    tog_sync_reg <= tog_sync_next;
    tog_seen_reg <= tog_seen_next;
    wp_meta_reg <= wp_meta_next;
    wp_sync_reg <= wp_sync_next;
  end

  // A frame counts only if the serial clock ran since the last one; the snapshot is stable by now.
  assign frame_done = cs_sync_reg & ~cs_last_reg & (tog_sync_reg != tog_seen_reg);

  // Protection of [first, last] under the protect bits and the range invert bit, 64KB array.
  function automatic logic range_hit(input logic [15:0] first, input logic [15:0] last,
                                     input logic [4:0] prot, input logic invert);
    logic any;
    logic whole;
    logic [15:0] size_m1;
    logic [15:0] lo;
    logic [15:0] hi;
    any = 1'b0;
    whole = 1'b0;
    size_m1 = `FSW_SIZE_32K_M1;
    lo = 16'h0000;
    hi = `FSW_ARRAY_TOP;
    if (!prot[4]) begin
      any = (prot[1:0] != 2'h0);
      whole = any;
    end else begin
      case (prot[2:0])
        3'h0: any = 1'b0;
        3'h1: size_m1 = `FSW_SIZE_4K_M1;
        3'h2: size_m1 = `FSW_SIZE_8K_M1;
        3'h3: size_m1 = `FSW_SIZE_16K_M1;
        3'h7: whole = 1'b1;
        default: size_m1 = `FSW_SIZE_32K_M1;
      endcase
      if (prot[2:0] != 3'h0) begin
        any = 1'b1;
      end
    end
    if (any && !whole) begin
      if (prot[3]) begin
        hi = size_m1;
      end else begin
        lo = ~size_m1;
      end
    end
    if (invert) begin
      range_hit = !(any && first >= lo && last <= hi);
    end else begin
      range_hit = any && first <= hi && last >= lo;
    end
  endfunction

  // Status word and busy engine.
  logic [4:0] block_protect_reg, block_protect_next;
  logic [1:0] status_protect_reg, status_protect_next;
  logic quad_lane_enable_reg, quad_lane_enable_next;
  logic [2:0] security_lock_reg, security_lock_next;
  logic range_invert_reg, range_invert_next;
  logic write_latch_flag_reg, write_latch_flag_next;
  logic erase_paused_flag_reg, erase_paused_flag_next;
  logic program_paused_flag_reg, program_paused_flag_next;
  op_t op_reg, op_next;
  timer_t timer_reg, timer_next;
  timer_t status_out_reg, status_out_next;
  logic paused;
  logic busy_flag;
  logic idle;
  logic whole_frame;
  logic wp_high;
  logic status_open;
  logic [15:0] addr;
  logic [15:0] wipe_first;
  logic [15:0] wipe_last;
  logic array_hit;

  assign paused = erase_paused_flag_reg | program_paused_flag_reg;
  assign busy_flag = (op_reg != OP_IDLE) && !paused;
  assign idle = (op_reg == OP_IDLE);
  assign whole_frame = frame_done && !frame_partial_reg;
  // With quad lanes on, the pin is a data lane and no longer gates the status word.
  assign wp_high = wp_sync_reg | quad_lane_enable_reg;
  assign status_open = write_latch_flag_reg && ((status_protect_reg == 2'h0) ||
                       (status_protect_reg == 2'h1 && wp_high));
  assign addr = {arg2_reg, arg3_reg};

  always_comb begin
    wipe_first = 16'h0000;
    wipe_last = `FSW_ARRAY_TOP;
    case (cmd_byte_reg)
      `FSW_CMD_PAGE_WRITE: begin
        wipe_first = addr;
        wipe_last = addr;
      end
      `FSW_CMD_SECTOR_WIPE: begin
        wipe_first = addr & ~`FSW_SIZE_4K_M1;
        wipe_last = addr | `FSW_SIZE_4K_M1;
      end
      `FSW_CMD_BLOCK32_WIPE: begin
        wipe_first = addr & ~`FSW_SIZE_32K_M1;
        wipe_last = addr | `FSW_SIZE_32K_M1;
      end
      default: wipe_first = 16'h0000;
    endcase
    array_hit = range_hit(wipe_first, wipe_last, block_protect_reg, range_invert_reg);
  end

  always_comb begin
    block_protect_next = block_protect_reg;
    status_protect_next = status_protect_reg;
    quad_lane_enable_next = quad_lane_enable_reg;
    security_lock_next = security_lock_reg;
    range_invert_next = range_invert_reg;
    write_latch_flag_next = write_latch_flag_reg;
    erase_paused_flag_next = erase_paused_flag_reg;
    program_paused_flag_next = program_paused_flag_reg;
    op_next = op_reg;
    timer_next = timer_reg;
    if (busy_flag) begin
      timer_next = timer_reg - 16'h0001;
      if (timer_reg <= 16'h0001) begin
        op_next = OP_IDLE;
        write_latch_flag_next = 1'b0;
        timer_next = 16'h0000;
      end
    end
    // Frames with a partial last byte fall through untouched.
    if (whole_frame) begin
      case (cmd_byte_reg)
        `FSW_CMD_WRITE_ENABLE: begin
          if (idle) begin
            write_latch_flag_next = 1'b1;
          end
        end
        `FSW_CMD_WRITE_DISABLE: begin
          if (idle) begin
            write_latch_flag_next = 1'b0;
          end
        end
        `FSW_CMD_STATUS_WRITE: begin
          // A refused write leaves all fields and the engine alone.
          if (idle && status_open && frame_bytes_reg >= `FSW_LEN_STATUS_MIN) begin
            block_protect_next = arg1_reg[6:2];
            status_protect_next[0] = arg1_reg[7];
            if (frame_bytes_reg >= `FSW_LEN_STATUS_FULL) begin
              status_protect_next[1] = arg2_reg[0];
              quad_lane_enable_next = arg2_reg[1];
              security_lock_next = security_lock_reg | arg2_reg[5:3];
              range_invert_next = arg2_reg[6];
            end
            op_next = OP_STATUS;
            timer_next = timer_t'(`FSW_STATUS_CYCLES);
          end
        end
        `FSW_CMD_PAGE_WRITE: begin
          if (idle && write_latch_flag_reg && frame_bytes_reg >= `FSW_LEN_PAGE_MIN && !array_hit) begin
            op_next = OP_PROGRAM;
            timer_next = timer_t'(`FSW_PROGRAM_CYCLES);
          end
        end
        `FSW_CMD_SECTOR_WIPE, `FSW_CMD_BLOCK32_WIPE, `FSW_CMD_BLOCK64_WIPE: begin
          if (idle && write_latch_flag_reg && frame_bytes_reg == `FSW_LEN_ADDR && !array_hit) begin
            op_next = OP_ERASE;
            timer_next = (cmd_byte_reg == `FSW_CMD_SECTOR_WIPE) ? timer_t'(`FSW_SECTOR_CYCLES) :
                         timer_t'(`FSW_BLOCK_CYCLES);
          end
        end
        `FSW_CMD_CHIP_WIPE_A, `FSW_CMD_CHIP_WIPE_B: begin
          if (idle && write_latch_flag_reg && frame_bytes_reg == `FSW_LEN_CMD && !array_hit) begin
            op_next = OP_ERASE;
            timer_next = timer_t'(CHIP_WIPE_CYCLES);
          end
        end
        `FSW_CMD_SUSPEND: begin
          if (busy_flag && op_reg == OP_ERASE) begin
            erase_paused_flag_next = 1'b1;
          end
          if (busy_flag && op_reg == OP_PROGRAM) begin
            program_paused_flag_next = 1'b1;
          end
        end
        `FSW_CMD_RESUME: begin
          erase_paused_flag_next = 1'b0;
          program_paused_flag_next = 1'b0;
        end
        default: op_next = op_next;
      endcase
    end
    if (i_power_cycle) begin
      op_next = OP_IDLE;
      timer_next = 16'h0000;
      write_latch_flag_next = 1'b0;
      erase_paused_flag_next = 1'b0;
      program_paused_flag_next = 1'b0;
      if (status_protect_reg == 2'h2) begin
        status_protect_next = 2'h0;
      end
    end
    if (i_rst) begin
      block_protect_next = `FSW_RST_PROTECT;
      status_protect_next = `FSW_RST_STATUS_PROT;
      quad_lane_enable_next = 1'b0;
      security_lock_next = `FSW_RST_LOCK;
      range_invert_next = 1'b0;
      write_latch_flag_next = 1'b0;
      erase_paused_flag_next = 1'b0;
      program_paused_flag_next = 1'b0;
      op_next = OP_IDLE;
      timer_next = 16'h0000;
    end
    status_out_next = `FSW_RST_WORD;
    if (!i_rst) begin
      status_out_next[`FSW_BIT_BUSY] = busy_flag;
      status_out_next[`FSW_BIT_WRITE_LATCH] = write_latch_flag_reg;
      status_out_next[`FSW_BIT_PROTECT_HI:`FSW_BIT_PROTECT_LO] = block_protect_reg;
      status_out_next[`FSW_BIT_STATUS_PROT_LO] = status_protect_reg[0];
      status_out_next[`FSW_BIT_STATUS_PROT_HI] = status_protect_reg[1];
      status_out_next[`FSW_BIT_QUAD_LANE] = quad_lane_enable_reg;
      status_out_next[`FSW_BIT_PROGRAM_PAUSED] = program_paused_flag_reg;
      status_out_next[`FSW_BIT_LOCK_HI:`FSW_BIT_LOCK_LO] = security_lock_reg;
      status_out_next[`FSW_BIT_RANGE_INVERT] = range_invert_reg;
      status_out_next[`FSW_BIT_ERASE_PAUSED] = erase_paused_flag_reg;
    end
  end

  always_ff @(posedge i_clk) begin
    block_protect_reg <= block_protect_next;
    status_protect_reg <= status_protect_next;
    quad_lane_enable_reg <= quad_lane_enable_next;
    security_lock_reg <= security_lock_next;
    range_invert_reg <= range_invert_next;
    write_latch_flag_reg <= write_latch_flag_next;
    erase_paused_flag_reg <= erase_paused_flag_next;
    program_paused_flag_reg <= program_paused_flag_next;
    op_reg <= op_next;
    timer_reg <= timer_next;
    status_out_reg <= status_out_next;
  end

  assign o_status_word = status_out_reg;
  assign o_quad_lane_enable = quad_lane_enable_reg;
  assign o_security_lock = security_lock_reg;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);

  busy_flag_rise_a: assert property ($rose(busy_flag) |=> o_status_word[`FSW_BIT_BUSY] [*2])
    else $error("busy flag not reported");
  latch_gate_a: assert property (idle && op_next != OP_IDLE |-> write_latch_flag_reg)
    else $error("operation started without write latch");
  protect_hold_a: assert property (!(whole_frame && cmd_byte_reg == `FSW_CMD_STATUS_WRITE)
    |=> $stable(block_protect_reg))
    else $error("protect bits changed without status write");
  range_refuse_a: assert property (whole_frame && idle && array_hit && cmd_byte_reg == `FSW_CMD_PAGE_WRITE
    |=> op_reg == OP_IDLE)
    else $error("program in protected range started");
  chip_wipe_a: assert property (whole_frame && idle && write_latch_flag_reg && frame_bytes_reg == `FSW_LEN_CMD
    && (cmd_byte_reg == `FSW_CMD_CHIP_WIPE_A || cmd_byte_reg == `FSW_CMD_CHIP_WIPE_B)
    && block_protect_reg[2:0] == 3'h7 && range_invert_reg
    |=> op_reg == OP_ERASE)
    else $error("chip erase not executed");
  hw_lock_a: assert property (status_protect_reg == 2'h1 && !wp_high
    |=> $stable(block_protect_reg) && $stable(status_protect_reg))
    else $error("status word written while pin locked");
  supply_lock_a: assert property (status_protect_reg[1] && !i_power_cycle
    |=> $stable(block_protect_reg) && $stable(range_invert_reg))
    else $error("locked status word changed");
  lock_sticky_a: assert property ((security_lock_reg & $past(security_lock_reg)) == $past(security_lock_reg))
    else $error("security lock bit cleared");
  resume_clear_a: assert property (whole_frame && cmd_byte_reg == `FSW_CMD_RESUME
    |=> ##1 !o_status_word[`FSW_BIT_ERASE_PAUSED] && !o_status_word[`FSW_BIT_PROGRAM_PAUSED])
    else $error("paused flags not cleared");
  partial_drop_a: assert property (frame_done && frame_partial_reg && !i_power_cycle && !busy_flag
    |=> $stable(write_latch_flag_reg) && op_reg == $past(op_reg))
    else $error("partial frame acted on");
  done_clear_a: assert property (busy_flag && timer_reg == 16'h0001 && !i_power_cycle
    |=> !write_latch_flag_reg && idle ##1 !o_status_word[`FSW_BIT_BUSY])
    else $error("completion did not clear flags");

  status_write_c: cover property (idle ##1 op_reg == OP_STATUS);
  suspend_c: cover property (busy_flag ##1 erase_paused_flag_reg);
  refuse_c: cover property (whole_frame && array_hit && write_latch_flag_reg);
  power_cycle_c: cover property (status_protect_reg == 2'h2 ##1 i_power_cycle);
endmodule

//--- verification/spi_host_model.sv
`timescale 1ns/1ps
module spi_host_model (
  output logic o_sclk,
  output logic o_cs_n,
  output logic o_si
);
  initial begin
    o_sclk = 1'b0;
    o_cs_n = 1'b1;
    o_si = 1'b0;
  end

  // Sends the bytes MSB first on a 64 ns serial clock that only runs inside the frame.
  // A non-zero drop cuts the last bits off, for frames that must be turned away.
  task automatic send(input logic [7:0] b[$], input int drop);
    int n;
    n = 8 * b.size() - drop;
    o_cs_n = 1'b0;
    #40;
    for (int i = 0; i < n; i++) begin
      o_si = b[i / 8][7 - (i % 8)];
      #32 o_sclk = 1'b1;
      #32 o_sclk = 1'b0;
    end
    #32;
    o_cs_n = 1'b1;
    // The data line is inverted, so it no longer holds the last bit.
    o_si = ~o_si;
    #400;
  endtask
endmodule

//--- verification/flash_status_write_protect_tb.sv
`timescale 1ns/1ps
module flash_status_write_protect_tb;
  import flash_status_pkg::*;
  logic i_clk;
  logic i_rst;
  logic i_power_cycle;
  logic i_wp_n;
  logic sclk;
  logic cs_n;
  logic si;
  logic quad;
  logic [2:0] lock;
  timer_t status_w;
  int num_errors = 0;
  int cmp_count = 0;

  flash_status_write_protect #(.CHIP_WIPE_CYCLES(20)) dut_u (
    .i_clk(i_clk), .i_rst(i_rst), .i_power_cycle(i_power_cycle), .i_sclk(sclk), .i_cs_n(cs_n),
    .i_si(si), .i_wp_n(i_wp_n), .o_status_word(status_w), .o_quad_lane_enable(quad), .o_security_lock(lock)
  );

  spi_host_model host_u (.o_sclk(sclk), .o_cs_n(cs_n), .o_si(si));

  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end

  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
    #10;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic fr(input logic [7:0] b[$], input int drop = 0);
    host_u.send(b, drop);
    tick(8);
  endtask

  task automatic wren;
    fr('{8'h06});
  endtask

  task automatic status_word_write_cmd(input logic [15:0] w);
    fr('{8'h01, w[7:0], w[15:8]});
  endtask

  task automatic settle;
    for (int k = 0; k < 5000 && status_w[0] !== 1'b0; k++) tick(1);
    tick(2);
  endtask

  task automatic pulse_power;
    i_power_cycle = 1'b1;
    tick(1);
    i_power_cycle = 1'b0;
    tick(4);
  endtask

  task automatic t_defaults;
    chk(status_w, 16'h0000);
    chk(16'(quad), 16'h0000);
    chk(16'(lock), 16'h0000);
  endtask

  task automatic t_latch_gate;
    status_word_write_cmd(16'h0004);
    chk(status_w, 16'h0000);
    fr('{8'h20, 8'h00, 8'h10, 8'h00});
    chk(status_w, 16'h0000);
    fr('{8'h06}, 1);
    chk(status_w, 16'h0000);
    wren;
    chk(status_w, 16'h0002);
    fr('{8'h04});
    chk(status_w, 16'h0000);
    wren;
    chk(status_w, 16'h0002);
  endtask

  task automatic t_store_fields;
    status_word_write_cmd(16'h4844);
    chk(status_w, 16'h4847);
    settle;
    chk(status_w, 16'h4844);
    chk(16'(lock), 16'h0001);
  endtask

  task automatic t_range_suspend;
    wren;
    fr('{8'h20, 8'h00, 8'hE0, 8'h00});
    chk(status_w, 16'h4846);
    fr('{8'h20, 8'h00, 8'hF0, 8'h00});
    chk(status_w, 16'h4847);
    fr('{8'h75});
    chk(status_w, 16'hC846);
    fr('{8'h7A});
    chk(status_w, 16'h4847);
    settle;
    chk(status_w, 16'h4844);
  endtask

  task automatic t_lock_sticky;
    wren;
    status_word_write_cmd(16'h4044);
    settle;
    chk(status_w, 16'h4844);
  endtask

  task automatic t_status_modes;
    wren;
    status_word_write_cmd(16'h48C4);
    settle;
    chk(status_w, 16'h48C4);
    i_wp_n = 1'b0;
    wren;
    status_word_write_cmd(16'h4880);
    chk(status_w, 16'h48C6);
    i_wp_n = 1'b1;
    // The pin is driven by the bench, never tied, while the quad lane bit is set.
    status_word_write_cmd(16'h4B00);
    settle;
    chk(status_w, 16'h4B00);
    chk(16'(quad), 16'h0001);
    wren;
    status_word_write_cmd(16'h4800);
    chk(status_w, 16'h4B02);
    pulse_power;
    chk(status_w, 16'h4A00);
    i_wp_n = 1'b0;
    wren;
    status_word_write_cmd(16'h419C);
    settle;
    chk(status_w, 16'h499C);
    i_wp_n = 1'b1;
  endtask

  task automatic t_otp_chip;
    wren;
    fr('{8'h60});
    chk(status_w, 16'h499F);
    settle;
    chk(status_w, 16'h499C);
    wren;
    fr('{8'hC7});
    chk(status_w, 16'h499F);
    settle;
    chk(status_w, 16'h499C);
    wren;
    fr('{8'hD8, 8'h00, 8'h00, 8'h00});
    chk(status_w, 16'h499F);
    settle;
    chk(status_w, 16'h499C);
    wren;
    status_word_write_cmd(16'h0000);
    chk(status_w, 16'h499E);
    fr('{8'h02, 8'h00, 8'h00, 8'h00, 8'hA5});
    chk(status_w, 16'h499F);
    fr('{8'h75});
    chk(status_w, 16'h4D9E);
    pulse_power;
    chk(status_w, 16'h499C);
  endtask

  initial begin
    i_rst = 1'b1;
    i_power_cycle = 1'b0;
    i_wp_n = 1'b1;
    tick(5);
    i_rst = 1'b0;
    tick(3);
    t_defaults;
    t_latch_gate;
    t_store_fields;
    t_range_suspend;
    t_lock_sticky;
    t_status_modes;
    t_otp_chip;
    tally_and_finish;
  end

  initial begin
    #3000000;
    num_errors++;
    tally_and_finish;
  end
endmodule
